// [hw/oad_decoder.v]
// Purpose: prefix recognition, operand fetch and effective address forming
// Assumes: code and data bytes arrive one per accepted request, in order
// Notes: exact opcode map is modelled by column/row groups
//
// Contract
// RULE1 - direct short: one byte, address 00-FF
// RULE2 - direct long: two bytes form 16-bit address
// RULE3 - indexed address is unsigned index plus offset
// RULE4 - indexed no offset: no byte, index alone
// RULE5 - indexed short: byte offset, up to 1FE
// RULE6 - indexed long: two-byte offset, full space
// RULE7 - indirect: pointer address byte, operand from memory
// RULE8 - indirect short: byte pointer, address 00-FF
// RULE9 - indirect long modes read word pointer
// RULE10 - indirect indexed adds index to pointer value
// RULE11 - indirect indexed short reaches up to 1FE
// RULE12 - relative adds signed 8-bit offset to PC
// RULE13 - relative offset direct or from memory
// RULE14 - 63 instructions, one to four bytes
// RULE15 - prefix precedes opcode, then 0-2 bytes
// RULE16 - prefix 90 swaps X for Y
// RULE17 - prefix 92 selects indirect forms
// RULE18 - prefix 91 selects Y indirect indexed
// RULE19 - undefined code raises a reset
// RULE20 - valid prefix plus valid opcode never resets
// RULE21 - PC already points past jump instruction
// RULE22 - bytes zero-extended, index sums carry upward
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module oad_decoder #(
    parameter ADDR_W = 16
) (
    input  wire              ref_clk,
    input  wire              rst_n,
    input  wire              byte_valid,
    input  wire [7:0]        byte_data,
    output wire              byte_ready,
    output reg               byte_is_data_r,
    output reg  [ADDR_W-1:0] byte_addr_r,
    input  wire [7:0]        index_x,
    input  wire [7:0]        index_y,
    input  wire [ADDR_W-1:0] pc_next,
    output reg               ea_valid_r,
    output reg  [ADDR_W-1:0] ea_addr_r,
    output reg  [7:0]        opcode_r,
    output reg  [3:0]        mode_r,
    output reg               use_y_r,
    output reg  [2:0]        length_r,
    output reg               illegal_reset_r
);
    localparam S_PRE   = 3'h0;
    localparam S_OP1   = 3'h1;
    localparam S_OP2   = 3'h2;
    localparam S_PTR1  = 3'h3;
    localparam S_PTR2  = 3'h4;
    localparam S_DONE  = 3'h5;

    reg [2:0]        state_r;
    reg [2:0]        state_nxt;
    reg [7:0]        prefix_r;
    reg              have_pre_r;
    reg [7:0]        first_r;
    reg [7:0]        ptr_addr_r;
    reg              ptr_wr;

    // pointer bytes kept in a tiny memory so the long pointer can be re-read
    wire [7:0]       ptr_rd;
    oad_pointer_ram #(
        .DEPTH_LOG2 (2)
    ) oad_pointer_ram_i (
        .ref_clk (ref_clk),
        .wr_en   (ptr_wr),
        .wr_idx  (2'h0),
        .wr_data (byte_data),
        .rd_idx  (2'h0),
        .rd_data (ptr_rd)
    );

    function is_prefix;
        input [7:0] c;
        begin
            is_prefix = (c == `OAD_PRE_SWAP_Y) || (c == `OAD_PRE_IND_Y) || (c == `OAD_PRE_IND_X);
        end
    endfunction

    // undefined codes by column/row: sparse columns hold the gaps
    function is_legal;
        input [7:0] c;
        begin
            case (c[7:4])
                4'h3, 4'h4, 4'h5, 4'h6, 4'h7: is_legal = (c[3:0] != 4'h1) && (c[3:0] != 4'h2) &&
                                                         (c[3:0] != 4'h5) && (c[3:0] != 4'hb);
                4'h8: is_legal = (c[3:0] != 4'h2) && (c[3:0] != 4'h3) && (c[3:0] != 4'h5) &&
                                 (c[3:0] != 4'h6) && (c[3:0] != 4'h7) && (c[3:0] != 4'h9) &&
                                 (c[3:0] != 4'ha) && (c[3:0] != 4'hb) && (c[3:0] != 4'hc) &&
                                 (c[3:0] != 4'hd) && (c[3:0] != 4'he);
                4'ha: is_legal = (c[3:0] != 4'h7) && (c[3:0] != 4'hc);
                default: is_legal = 1'b1;
            endcase
        end
    endfunction

    // base mode from the opcode column
    function [3:0] base_mode;
        input [7:0] c;
        begin
            case (c[7:4])
                4'h0, 4'h1: base_mode = `OAD_M_DIR_S;
                4'h2:       base_mode = `OAD_M_REL_D;
                4'h3:       base_mode = `OAD_M_DIR_S;
                4'h4, 4'h5, 4'h8, 4'h9: base_mode = `OAD_M_INH;
                4'h6, 4'he: base_mode = `OAD_M_IDX_S;
                4'h7, 4'hf: base_mode = `OAD_M_IDX_0;
                4'ha:       base_mode = (c[3:0] == 4'hd) ? `OAD_M_REL_D : `OAD_M_IMM;
                4'hb:       base_mode = `OAD_M_DIR_S;
                4'hc:       base_mode = `OAD_M_DIR_L;
                4'hd:       base_mode = `OAD_M_IDX_L;
                default:    base_mode = `OAD_M_INH;
            endcase
        end
    endfunction

    // prefix 92/91 turn direct and X indexed into indirect forms
    function [3:0] apply_prefix;
        input [3:0] m;
        input [7:0] p;
        begin
            apply_prefix = m;
            if (p == `OAD_PRE_IND_X || p == `OAD_PRE_IND_Y) begin
                case (m)
                    `OAD_M_DIR_S: apply_prefix = `OAD_M_IND_S;   // RULE17
                    `OAD_M_DIR_L: apply_prefix = `OAD_M_IND_L;   // RULE17
                    `OAD_M_REL_D: apply_prefix = `OAD_M_REL_I;   // RULE17
                    `OAD_M_IDX_S: apply_prefix = `OAD_M_INDX_S;  // RULE17
                    `OAD_M_IDX_L: apply_prefix = `OAD_M_INDX_L;  // RULE17
                    default:      apply_prefix = m;
                endcase
            end
        end
    endfunction

    function [ADDR_W-1:0] zext;
        input [7:0] b;
        begin
            zext = {{(ADDR_W-8){1'b0}}, b};  // RULE22
        end
    endfunction

    wire       take   = byte_valid & byte_ready;
    wire [3:0] m_now  = apply_prefix(base_mode(byte_data), prefix_r);
    wire       y_now  = have_pre_r & ((prefix_r == `OAD_PRE_SWAP_Y) || (prefix_r == `OAD_PRE_IND_Y)); // RULE16 RULE18
    wire [7:0] idx    = use_y_r ? index_y : index_x;
    wire [ADDR_W-1:0] idx_z = zext(idx);

    assign byte_ready = (state_r != S_DONE) && !illegal_reset_r;

    always @* begin
        state_nxt = state_r;
        ptr_wr    = 1'b0;
        case (state_r)
            S_PRE: begin
                if (take && !is_prefix(byte_data) && is_legal(byte_data)) begin
                    case (m_now)
                        `OAD_M_INH, `OAD_M_IDX_0: state_nxt = S_DONE;  // RULE4
                        default:                  state_nxt = S_OP1;
                    endcase
                end
            end
            S_OP1: begin
                if (take) begin
                    case (mode_r)
                        `OAD_M_DIR_L, `OAD_M_IDX_L: state_nxt = S_OP2;  // RULE2 RULE6
                        `OAD_M_IND_S, `OAD_M_IND_L, `OAD_M_INDX_S, `OAD_M_INDX_L, `OAD_M_REL_I:
                            state_nxt = S_PTR1;  // RULE7
                        default: state_nxt = S_DONE;
                    endcase
                end
            end
            S_OP2: begin
                if (take) begin
                    state_nxt = S_DONE;
                end
            end
            S_PTR1: begin
                if (take) begin
                    ptr_wr = 1'b1;
                    state_nxt = (mode_r == `OAD_M_IND_L || mode_r == `OAD_M_INDX_L) ? S_PTR2 : S_DONE; // RULE9
                end
            end
            S_PTR2: begin
                if (take) begin
                    state_nxt = S_DONE;
                end
            end
            S_DONE: state_nxt = S_PRE;
            default: state_nxt = S_PRE;
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r         <= S_PRE;
            prefix_r        <= 8'h00;
            have_pre_r      <= 1'b0;
            first_r         <= 8'h00;
            ptr_addr_r      <= 8'h00;
            byte_is_data_r  <= 1'b0;
            byte_addr_r     <= `OAD_ADDR_RESET;
            ea_valid_r      <= 1'b0;
            ea_addr_r       <= `OAD_ADDR_RESET;
            opcode_r        <= 8'h00;
            mode_r          <= `OAD_M_INH;
            use_y_r         <= 1'b0;
            length_r        <= 3'h0;
            illegal_reset_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            ea_valid_r <= 1'b0;
            case (state_r)
                S_PRE: begin
                    if (take) begin
                        if (is_prefix(byte_data) && !have_pre_r) begin
                            prefix_r   <= byte_data;  // RULE15
                            have_pre_r <= 1'b1;
                            length_r   <= 3'h1;
                        end else if (!is_legal(byte_data) || is_prefix(byte_data)) begin
                            illegal_reset_r <= 1'b1;  // RULE19
                        end else begin
                            // no pairing check: valid prefix with valid opcode is accepted
                            opcode_r <= byte_data;  // RULE20
                            mode_r   <= m_now;
                            use_y_r  <= y_now;
                            length_r <= length_r + 3'h1;  // RULE14
                            if (m_now == `OAD_M_IDX_0) begin
                                ea_addr_r  <= y_now ? zext(index_y) : zext(index_x);  // RULE4
                                ea_valid_r <= 1'b1;
                            end else if (m_now == `OAD_M_INH) begin
                                ea_valid_r <= 1'b1;
                                ea_addr_r  <= `OAD_ADDR_RESET;
                            end
                        end
                    end
                end
                S_OP1: begin
                    if (take) begin
                        first_r  <= byte_data;
                        length_r <= length_r + 3'h1;
                        case (mode_r)
                            `OAD_M_IMM: ea_addr_r <= pc_next;
                            `OAD_M_DIR_S: ea_addr_r <= zext(byte_data);  // RULE1
                            `OAD_M_IDX_S: ea_addr_r <= zext(byte_data) + idx_z;  // RULE3 RULE5
                            // next pc already past the jump when adding
                            `OAD_M_REL_D: ea_addr_r <= pc_next + {{(ADDR_W-8){byte_data[7]}}, byte_data}; // RULE12 RULE13 RULE21
                            default: ea_addr_r <= ea_addr_r;
                        endcase
                        if (state_nxt == S_PTR1) begin
                            ptr_addr_r     <= byte_data;  // RULE7
                            byte_is_data_r <= 1'b1;
                            byte_addr_r    <= zext(byte_data);
                        end
                        if (state_nxt == S_DONE) begin
                            ea_valid_r <= 1'b1;
                        end
                    end
                end
                S_OP2: begin
                    if (take) begin
                        length_r <= length_r + 3'h1;
                        if (mode_r == `OAD_M_IDX_L) begin
                            ea_addr_r <= {first_r, byte_data} + idx_z;  // RULE6 RULE3
                        end else begin
                            ea_addr_r <= {first_r, byte_data};  // RULE2
                        end
                        ea_valid_r <= 1'b1;
                    end
                end
                S_PTR1: begin
                    if (take) begin
                        // high pointer byte lands in the store through ptr_wr
                        case (mode_r)
                            `OAD_M_IND_S:  ea_addr_r <= zext(byte_data);  // RULE8
                            `OAD_M_INDX_S: ea_addr_r <= zext(byte_data) + idx_z;  // RULE10 RULE11
                            `OAD_M_REL_I:  ea_addr_r <= pc_next + {{(ADDR_W-8){byte_data[7]}}, byte_data}; // RULE13 RULE21
                            default:       ea_addr_r <= ea_addr_r;
                        endcase
                        if (state_nxt == S_PTR2) begin
                            byte_addr_r <= zext(ptr_addr_r + 8'h01);
                        end else begin
                            byte_is_data_r <= 1'b0;
                            ea_valid_r     <= 1'b1;
                        end
                    end
                end
                S_PTR2: begin
                    if (take) begin
                        byte_is_data_r <= 1'b0;
                        if (mode_r == `OAD_M_INDX_L) begin
                            // high byte comes back from the pointer store
                            ea_addr_r <= {ptr_rd, byte_data} + idx_z;  // RULE9 RULE10
                        end else begin
                            ea_addr_r <= {ptr_rd, byte_data};  // RULE9
                        end
                        ea_valid_r <= 1'b1;
                    end
                end
                S_DONE: begin
                    prefix_r   <= 8'h00;
                    have_pre_r <= 1'b0;
                    length_r   <= 3'h0;
                end
                default: begin
                    prefix_r <= 8'h00;
                end
            endcase
        end
    end
endmodule // oad_decoder
`default_nettype wire

// [hw/oad_map.vh]
// Purpose: constants for the operand address decoder
// Assumes: byte-wide code stream, 16-bit address space
// Notes: opcode groups follow the usual column/row layout of the core
`ifndef OAD_MAP_VH
`define OAD_MAP_VH
`define OAD_PRE_SWAP_Y     8'h90
`define OAD_PRE_IND_Y      8'h91
`define OAD_PRE_IND_X      8'h92
`define OAD_PC_RESET       16'h0000
`define OAD_ADDR_RESET     16'h0000
`define OAD_MAX_BYTES      3'h4
// addressing modes
`define OAD_M_INH          4'h0
`define OAD_M_IMM          4'h1
`define OAD_M_DIR_S        4'h2
`define OAD_M_DIR_L        4'h3
`define OAD_M_IDX_0        4'h4
`define OAD_M_IDX_S        4'h5
`define OAD_M_IDX_L        4'h6
`define OAD_M_IND_S        4'h7
`define OAD_M_IND_L        4'h8
`define OAD_M_INDX_S       4'h9
`define OAD_M_INDX_L       4'ha
`define OAD_M_REL_D        4'hb
`define OAD_M_REL_I        4'hc
`endif

// [hw/oad_pointer_ram.v]
// Purpose: small pointer scratch memory holding fetched pointer bytes
// Assumes: one write and one read port on ref_clk
// Notes: read data is registered
`timescale 1ns/10ps
`default_nettype none
module oad_pointer_ram #(
    parameter DEPTH_LOG2 = 2
) (
    input  wire                  ref_clk,
    input  wire                  wr_en,
    input  wire [DEPTH_LOG2-1:0] wr_idx,
    input  wire [7:0]            wr_data,
    input  wire [DEPTH_LOG2-1:0] rd_idx,
    output reg  [7:0]            rd_data
);
    reg [7:0] mem [0:(1<<DEPTH_LOG2)-1];

    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        // write-through: a byte stored now is readable on the next cycle
        rd_data <= (wr_en && (wr_idx == rd_idx)) ? wr_data : mem[rd_idx];
    end
endmodule // oad_pointer_ram
`default_nettype wire

// [bench/oad_decoder_monitor.sv]
// Purpose: timing and address range checks on the operand address decoder
// Assumes: one ref_clk domain, rst_n synchronous active low
// Notes: sees top ports only, attached by the bind at the foot
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module oad_decoder_monitor #(
    parameter ADDR_W = 16
) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              byte_ready,
    input wire logic [7:0]        index_x,
    input wire logic [ADDR_W-1:0] pc_next,
    input wire logic              ea_valid_r,
    input wire logic [ADDR_W-1:0] ea_addr_r,
    input wire logic [3:0]        mode_r,
    input wire logic              use_y_r,
    input wire logic [2:0]        length_r,
    input wire logic              illegal_reset_r
);
    // wraps modulo 2^16, so backward targets land high
    wire [ADDR_W-1:0] rel_diff = ea_addr_r - pc_next;
    default clocking dclk @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_ea_one_cycle: assert property ($rose(ea_valid_r) |=> !ea_valid_r)
        else $error("ea_valid_r longer than one cycle");
    chk_done_refuses: assert property (ea_valid_r |-> !byte_ready)
        else $error("byte taken in completion cycle");
    chk_ready_returns: assert property (ea_valid_r && !illegal_reset_r |=> byte_ready)
        else $error("byte_ready not back after completion");
    chk_illegal_sticky: assert property (illegal_reset_r |=> illegal_reset_r)
        else $error("illegal flag dropped without reset");
    chk_illegal_blocks: assert property (illegal_reset_r |-> !byte_ready && !ea_valid_r)
        else $error("decoder active after illegal code");
    chk_dir_short_page: assert property (ea_valid_r && mode_r == `OAD_M_DIR_S |-> ea_addr_r[ADDR_W-1:8] == 0)
        else $error("direct short outside page zero");
    chk_idx_none_x: assert property (ea_valid_r && mode_r == `OAD_M_IDX_0 && !use_y_r
        |-> ea_addr_r == {{(ADDR_W-8){1'b0}}, index_x})
        else $error("indexed no offset not equal to X");
    chk_short_idx_cap: assert property (ea_valid_r && (mode_r == `OAD_M_IDX_S || mode_r == `OAD_M_INDX_S)
        |-> ea_addr_r <= 16'h01fe)
        else $error("short indexed address above 1fe");
    chk_ind_short_page: assert property (ea_valid_r && mode_r == `OAD_M_IND_S |-> ea_addr_r[ADDR_W-1:8] == 0)
        else $error("indirect short outside page zero");
    chk_rel_span: assert property (ea_valid_r && (mode_r == `OAD_M_REL_D || mode_r == `OAD_M_REL_I)
        |-> rel_diff <= 16'h007f || rel_diff >= 16'hff80)
        else $error("relative target out of signed byte span");
    chk_len_bound: assert property (ea_valid_r |-> length_r >= 3'h1 && length_r <= `OAD_MAX_BYTES)
        else $error("instruction length outside one to four");
endmodule // oad_decoder_monitor
bind oad_decoder oad_decoder_monitor #(.ADDR_W(ADDR_W)) oad_decoder_monitor_i (.ref_clk, .rst_n, .byte_ready,
    .index_x, .pc_next, .ea_valid_r, .ea_addr_r, .mode_r, .use_y_r, .length_r, .illegal_reset_r);
`default_nettype wire

// [bench/test_oad_decoder.sv]
// Purpose: directed bench for the operand address decoder
// Assumes: byte handshake on ref_clk, pointer bytes fed in order
// Notes: opcode choices stay inside the column map of the decoder
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module test_oad_decoder;
    logic        ref_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    logic        byte_valid = 1'b0;
    logic [7:0]  byte_data  = 8'h00;
    logic [7:0]  index_x    = 8'h00;
    logic [7:0]  index_y    = 8'h00;
    logic [15:0] pc_next    = 16'h0000;
    wire         byte_ready, byte_is_data_r, ea_valid_r, use_y_r, illegal_reset_r;
    wire [15:0]  byte_addr_r, ea_addr_r;
    wire [7:0]   opcode_r;
    wire [3:0]   mode_r;
    wire [2:0]   length_r;
    int          miscompares = 0;
    int          cmp_count   = 0;
    logic        isd [0:7];
    logic [15:0] pa  [0:7];

    always #2 ref_clk = ~ref_clk;

    oad_decoder oad_decoder_i (.ref_clk(ref_clk), .rst_n(rst_n), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready(byte_ready), .byte_is_data_r(byte_is_data_r), .byte_addr_r(byte_addr_r), .index_x(index_x),
        .index_y(index_y), .pc_next(pc_next), .ea_valid_r(ea_valid_r), .ea_addr_r(ea_addr_r),
        .opcode_r(opcode_r), .mode_r(mode_r), .use_y_r(use_y_r), .length_r(length_r),
        .illegal_reset_r(illegal_reset_r));

    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset;
        rst_n      <= 1'b0;
        byte_valid <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
    endtask

    // hold valid and data until the edge that samples ready high
    task automatic put(input logic [7:0] b, input int k);
        int n;
        byte_valid <= 1'b1;
        byte_data  <= b;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (byte_ready !== 1'b1 && n < 40);
        isd[k] = byte_is_data_r;
        pa[k]  = byte_addr_r;
        chk(16'(byte_ready), 16'h0001);
    endtask

    task automatic run(input logic [39:0] bs, input int nb, input logic [3:0] em, input logic [15:0] ea,
                       input logic [2:0] len, input logic ey);
        int n;
        for (int k = 0; k < nb; k++) put(bs[39-8*k -: 8], k);
        byte_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ea_valid_r !== 1'b1 && n < 20);
        chk(16'(ea_valid_r), 16'h0001);
        chk(16'(mode_r), 16'(em));
        chk(16'(opcode_r), 16'((bs[39:32] inside {8'h90, 8'h91, 8'h92}) ? bs[31:24] : bs[39:32]));
        if (em != `OAD_M_INH) chk(ea_addr_r, ea);
        chk(16'(length_r), 16'(len));
        chk(16'(use_y_r), 16'(ey));
        chk(16'(illegal_reset_r), 16'h0000);
    endtask

    task automatic s_direct;
        run(40'hb655000000, 2, `OAD_M_DIR_S, 16'h0055, 3'h2, 1'b0);
        run(40'hc6ab120000, 3, `OAD_M_DIR_L, 16'hab12, 3'h3, 1'b0);
        run(40'h4c00000000, 1, `OAD_M_INH, 16'h0000, 3'h1, 1'b0);
    endtask

    task automatic s_indexed;
        index_x <= 8'hff;
        index_y <= 8'h80;
        run(40'hf600000000, 1, `OAD_M_IDX_0, 16'h00ff, 3'h1, 1'b0);
        run(40'he6ff000000, 2, `OAD_M_IDX_S, 16'h01fe, 3'h2, 1'b0);
        run(40'hd612000000, 3, `OAD_M_IDX_L, 16'h12ff, 3'h3, 1'b0);
        run(40'h90f6000000, 2, `OAD_M_IDX_0, 16'h0080, 3'h2, 1'b1);
        run(40'h90e6010000, 3, `OAD_M_IDX_S, 16'h0081, 3'h3, 1'b1);
    endtask

    task automatic s_indirect;
        run(40'h92b6407700, 4, `OAD_M_IND_S, 16'h0077, 3'h3, 1'b0);
        chk(16'(isd[3]), 16'h0001);
        chk(pa[3], 16'h0040);
        run(40'h92c6fe1234, 5, `OAD_M_IND_L, 16'h1234, 3'h3, 1'b0);
        chk(pa[4], 16'h00ff);
    endtask

    task automatic s_ind_indexed;
        index_y <= 8'h01;
        run(40'h92e620ff00, 4, `OAD_M_INDX_S, 16'h01fe, 3'h3, 1'b0);
        run(40'h91e620ff00, 4, `OAD_M_INDX_S, 16'h0100, 3'h3, 1'b1);
        run(40'h92d6301234, 5, `OAD_M_INDX_L, 16'h1333, 3'h3, 1'b0);
        chk(pa[3], 16'h0030);
    endtask

    task automatic s_relative;
        pc_next <= 16'h1000;
        run(40'h2080000000, 2, `OAD_M_REL_D, 16'h0f80, 3'h2, 1'b0);
        run(40'h207f000000, 2, `OAD_M_REL_D, 16'h107f, 3'h2, 1'b0);
        run(40'had10000000, 2, `OAD_M_REL_D, 16'h1010, 3'h2, 1'b0);
        run(40'h922050fe00, 4, `OAD_M_REL_I, 16'h0ffe, 3'h3, 1'b0);
        chk(pa[3], 16'h0050);
        run(40'ha655000000, 2, `OAD_M_IMM, 16'h1000, 3'h2, 1'b0);
    endtask

    // prefix on an opcode it does not modify must not trap
    task automatic s_prefix_combo;
        run(40'h924c000000, 2, `OAD_M_INH, 16'h0000, 3'h2, 1'b0);
    endtask

    task automatic s_illegal(input logic [15:0] code, input int nb);
        for (int k = 0; k < nb; k++) put(code[15-8*k -: 8], k);
        byte_valid <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(16'(illegal_reset_r), 16'h0001);
        chk(16'(byte_ready), 16'h0000);
        do_reset;
        chk(16'(illegal_reset_r), 16'h0000);
    endtask

    initial begin
        do_reset;
        chk(16'(illegal_reset_r), 16'h0000);
        s_direct;
        s_indexed;
        s_indirect;
        s_ind_indexed;
        s_relative;
        s_prefix_combo;
        s_illegal(16'h3100, 1);
        s_illegal(16'h9090, 2);
        s_illegal(16'h8c00, 1);
        s_illegal(16'ha700, 1);
        run(40'hb6ff000000, 2, `OAD_M_DIR_S, 16'h00ff, 3'h2, 1'b0);
        tally_and_finish;
    end

    // whole run needs well under a thousand cycles
    initial begin
        #20000;
        miscompares++;
        tally_and_finish;
    end
endmodule // test_oad_decoder
`default_nettype wire
